// File: rtl/trig_detector.sv
// Protocol trigger detector for CAN, LIN and I2C; I2C on fixed input channels, CAN and LIN on a selected one, except the CAN pair on ch0 and ch1 at source zero.
// Assumes synchronous config inputs, held stable while run is high.
`timescale 1ns/1ps
`include "trig_params.svh"
module trig_detector
    import trig_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [5:0]        chan_in,
    input  wire logic              run,
    input  wire proto_type         proto,
    input  wire logic              can_on_end,
    input  wire can_sig_type       can_sig,
    input  wire logic [1:0]        trig_source,
    input  wire logic [`DIV_W-1:0] bit_div,
    input  wire logic [1:0]        brk_len,
    input  wire i2c_cond_type      i2c_cond,
    input  wire logic              addr10_en,
    input  wire logic              thresh_manual,
    input  wire logic [7:0]        thresh_level,
    output logic                   trigger,
    output logic                   thresh_manual_out,
    output logic [7:0]             thresh_level_out,
    output logic                   addr10_seen,
    output logic                   read_seen,
    output logic                   busy
);
    // ==========================================================
    // Input capture
    logic [5:0] lines;
    logic [5:0] lines_d;

    input_sync u_sync
    (
        .clk    (clk),
        .resetn (resetn),
        .raw    (chan_in),
        .synced (lines)
    );

    // Previous sample for edge detection on synchronised lines
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            lines_d <= 6'h3f;
        else
            lines_d <= lines;
    end

    // Dominant means logic low on the chosen view of the bus
    function automatic logic pick_line(input logic [5:0] l, input logic [1:0] sel);
        pick_line = l[sel];
    endfunction

    // ==========================================================
    // Threshold mode and manual level pass-through, registered; automatic mode gives level 8'h80
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            thresh_manual_out <= 1'b0;
            thresh_level_out  <= 8'h00;
        end
        else
        begin
            thresh_manual_out <= thresh_manual;
            thresh_level_out  <= thresh_manual ? thresh_level : 8'h80;
        end
    end

    // ==========================================================
    // CAN / LIN serial line selection
    logic bus_rx;
    logic bus_rx_d;

    // Differential pair decoded as high minus low; single wire on ch0
    always_comb
    begin
        bus_rx   = 1'b1;
        bus_rx_d = 1'b1;
        if (proto == proto_can && trig_source == 2'h0)
        begin
            if (can_sig == can_single)
            begin
                bus_rx   = lines[0];
                bus_rx_d = lines_d[0];
            end
            else
            begin
                bus_rx   = ~(lines[0] & ~lines[1]);
                bus_rx_d = ~(lines_d[0] & ~lines_d[1]);
            end
        end
        else if (proto == proto_can || proto == proto_lin)
        begin
            // Source zero is the bus line itself; others are transceiver pins
            bus_rx   = pick_line(lines, trig_source);
            bus_rx_d = pick_line(lines_d, trig_source);
        end
    end

    logic fall_edge;
    logic mid_bit;
    logic bit_end;
    assign fall_edge = bus_rx_d & ~bus_rx;

    // Resynchronise bit timing on every falling edge
    bit_timer u_timer
    (
        .clk     (clk),
        .resetn  (resetn),
        .bit_div (bit_div),
        .restart (fall_edge),
        .mid_bit (mid_bit),
        .bit_end (bit_end)
    );

    // ==========================================================
    // CAN frame tracking: recessive run counter
    logic [3:0] rec_run;
    logic       in_frame;
    logic       can_event;

    // Frame end is seven recessive bits; idle after eleven
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rec_run  <= 4'h0;
            in_frame <= 1'b0;
        end
        else if (proto != proto_can || !run)
        begin
            rec_run  <= 4'h0;
            in_frame <= 1'b0;
        end
        else if (fall_edge && !in_frame && rec_run >= 4'(`CAN_IDLE_BITS))
            in_frame <= 1'b1;
        else if (mid_bit)
        begin
            if (!bus_rx)
                rec_run <= 4'h0;
            else if (rec_run != 4'hf)
                rec_run <= rec_run + 4'h1;
            if (in_frame && bus_rx && rec_run == 4'(`CAN_EOF_BITS - 1))
                in_frame <= 1'b0;
        end
    end

    // Start on the idle-to-dominant edge, end on the seventh recessive bit
    always_comb
    begin
        can_event = 1'b0;
        if (!can_on_end)
            can_event = fall_edge && !in_frame && rec_run >= 4'(`CAN_IDLE_BITS);
        else
            can_event = mid_bit && in_frame && bus_rx && rec_run == 4'(`CAN_EOF_BITS - 1);
    end

    // ==========================================================
    // LIN sync break measurement
    logic [4:0] dom_bits;
    logic [4:0] brk_min;
    logic       lin_event;

    // Break length select, 11 to 13 bits
    always_comb
    begin
        case (brk_len)
            `BRK_11: brk_min = 5'd11;
            `BRK_12: brk_min = 5'd12;
            `BRK_13: brk_min = 5'd13;
            default: brk_min = 5'd13;
        endcase
    end

    // Count whole dominant bits; saturate so long breaks still qualify
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            dom_bits <= 5'h0;
        else if (proto != proto_lin || bus_rx)
            dom_bits <= 5'h0;
        else if (bit_end && dom_bits != 5'h1f)
            dom_bits <= dom_bits + 5'h1;
    end

    // Fire on the rising edge that closes a long enough break
    assign lin_event = (proto == proto_lin) && !bus_rx_d && bus_rx && dom_bits >= brk_min;

    // ==========================================================
    // I2C condition detection
    logic sda;
    logic scl;
    logic sda_d;
    logic scl_d;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    assign sda      = lines[0];
    assign scl      = lines[1];
    assign sda_d    = lines_d[0];
    assign scl_d    = lines_d[1];
    assign start_cond = scl && scl_d && sda_d && !sda;
    assign stop_cond  = scl && scl_d && !sda_d && sda;
    assign scl_rise   = !scl_d && scl;

    i2c_state_type state;
    logic [2:0]    bit_cnt;
    logic [7:0]    shift;
    logic          framed;
    logic          first_byte;
    logic          ack_miss;

    // Byte and acknowledge tracking, sampled on clock rising edges
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state      <= i2c_idle;
            bit_cnt    <= 3'h0;
            shift      <= 8'h00;
            framed     <= 1'b0;
            first_byte <= 1'b0;
        end
        else if (proto != proto_i2c)
        begin
            state  <= i2c_idle;
            framed <= 1'b0;
        end
        else if (start_cond)
        begin
            state      <= i2c_data;
            bit_cnt    <= 3'h0;
            framed     <= 1'b1;
            first_byte <= 1'b1;
        end
        else if (stop_cond)
        begin
            state  <= i2c_idle;
            framed <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state)
                i2c_data:
                begin
                    shift   <= {shift[6:0], sda};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7)
                        state <= i2c_ack;
                end
                i2c_ack:
                begin
                    state      <= i2c_data;
                    first_byte <= 1'b0;
                end
                default: state <= i2c_idle;
            endcase
        end
    end

    // Acknowledge sampled high means nobody accepted the byte
    assign ack_miss = (proto == proto_i2c) && scl_rise && state == i2c_ack && sda;

    // Address byte decode, first byte after start
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr10_seen <= 1'b0;
            read_seen   <= 1'b0;
        end
        else if (proto == proto_i2c && scl_rise && state == i2c_ack && first_byte)
        begin
            // Ten-bit write prefix only counts when the option is on
            addr10_seen <= addr10_en && shift[7:3] == `I2C_ADDR10_PREFIX && !shift[0];
            read_seen   <= shift[0];
        end
    end

    logic i2c_event;
    // One condition chosen; a restart is a start seen while still framed
    always_comb
    begin
        case (i2c_cond)
            i2c_start:    i2c_event = start_cond;
            i2c_stop:     i2c_event = stop_cond;
            i2c_miss_ack: i2c_event = ack_miss;
            i2c_restart:  i2c_event = start_cond && framed;
            default:      i2c_event = 1'b0;
        endcase
    end

    // ==========================================================
    // Trigger output
    logic next_trigger;
    always_comb
    begin
        case (proto)
            proto_can: next_trigger = can_event;
            proto_lin: next_trigger = lin_event;
            proto_i2c: next_trigger = i2c_event;
            default:   next_trigger = 1'b0;
        endcase
    end

    // Source events are single-cycle, so the register is a single pulse
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trigger <= 1'b0;
            busy    <= 1'b0;
        end
        else
        begin
            trigger <= run && next_trigger;
            busy    <= (proto == proto_i2c) ? framed : in_frame || !bus_rx;
        end
    end
endmodule // trig_detector

// File: common/trig_params.svh
// Timing counts, field codes and reset values for the protocol trigger detector.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH

`define CLK_HZ              40000000
`define CAN_BAUD_MIN        10000
`define CAN_BAUD_MAX        1000000
`define LIN_BAUD_MIN        2400
`define LIN_BAUD_MAX        625000
// Cycles per bit at the slowest and fastest rates
`define CAN_DIV_MAX         (`CLK_HZ / `CAN_BAUD_MIN)
`define CAN_DIV_MIN         (`CLK_HZ / `CAN_BAUD_MAX)
`define LIN_DIV_MAX         (`CLK_HZ / `LIN_BAUD_MIN)
`define LIN_DIV_MIN         (`CLK_HZ / `LIN_BAUD_MAX)
`define DIV_W               15
`define CAN_EOF_BITS        7
`define CAN_IDLE_BITS       11
`define BRK_11              2'h1
`define BRK_12              2'h2
`define BRK_13              2'h3
`define I2C_ADDR10_PREFIX   5'h1e
`define SYNC_RESET          1'h1
`endif

// File: common/trig_pkg.sv
// Types shared by the protocol trigger detector.
// Assumes nothing beyond a SystemVerilog compiler.
package trig_pkg;
    // Protocol selection
    typedef enum logic [1:0] {
        proto_can = 2'b00,
        proto_lin = 2'b01,
        proto_i2c = 2'b10,
        proto_off = 2'b11
    } proto_type;
    // CAN signal type
    typedef enum logic [1:0] {
        can_high_speed = 2'b00,
        can_fault_tol  = 2'b01,
        can_single     = 2'b10
    } can_sig_type;
    // I2C trigger conditions
    typedef enum logic [1:0] {
        i2c_start    = 2'b00,
        i2c_stop     = 2'b01,
        i2c_miss_ack = 2'b10,
        i2c_restart  = 2'b11
    } i2c_cond_type;
    // I2C bit tracking state
    typedef enum logic [1:0] {
        i2c_idle = 2'b00,
        i2c_data = 2'b01,
        i2c_ack  = 2'b10
    } i2c_state_type;
endpackage

// File: rtl/input_sync.sv
// Two-stage synchroniser for a bank of bus lines.
// Assumes lines change freely against clk.
`timescale 1ns/1ps
`include "trig_params.svh"
module input_sync
    import trig_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [5:0] raw,
    output logic      [5:0] synced
);
    logic [5:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= {6{`SYNC_RESET}};
            synced <= {6{`SYNC_RESET}};
        end
        else
        begin
            stage1 <= raw;
            synced <= stage1;
        end
    end
endmodule // input_sync

// File: rtl/bit_timer.sv
// Bit-time enable generator, restartable on a bus edge.
// Assumes bit_div is held stable while running.
`timescale 1ns/1ps
`include "trig_params.svh"
module bit_timer
    import trig_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [`DIV_W-1:0] bit_div,
    input  wire logic              restart,
    output logic                   mid_bit,
    output logic                   bit_end
);
    logic [`DIV_W-1:0] count;

    // Count through one bit; pulses at middle and end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count   <= '0;
            mid_bit <= 1'b0;
            bit_end <= 1'b0;
        end
        else
        begin
            mid_bit <= (count == (bit_div >> 1));
            bit_end <= (count == bit_div - `DIV_W'(1));
            if (restart || count >= bit_div - `DIV_W'(1))
                count <= '0;
            else
                count <= count + `DIV_W'(1);
        end
    end
endmodule // bit_timer

// File: bench/trig_detector_sva.sv
// Port-level assertions for the protocol trigger detector.
// Assumes it is bound onto trig_detector by the testbench.
`timescale 1ns/1ps
`include "trig_params.svh"
module trig_detector_sva
    import trig_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [5:0]        chan_in,
    input wire logic              run,
    input wire proto_type         proto,
    input wire i2c_cond_type      i2c_cond,
    input wire logic              thresh_manual,
    input wire logic [7:0]        thresh_level,
    input wire logic              trigger,
    input wire logic              thresh_manual_out,
    input wire logic [7:0]        thresh_level_out,
    input wire logic              busy
);
    // ==========
    // Edges since reset; $past is meaningless before the third
    logic [1:0] up;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Start and stop seen raw at the pins, clock line high throughout
    sequence start_pin;
        $fell(chan_in[0]) && chan_in[1] && $past(chan_in[1]);
    endsequence
    sequence stop_pin;
        $rose(chan_in[0]) && chan_in[1] && $past(chan_in[1]);
    endsequence
    // ==========
    // Checks
    reset_quiet_a: assert property (up == 2'h1 |-> !trigger && !busy)
        else $error("outputs not clear after reset");
    pulse_once_a: assert property (trigger |=> !trigger)
        else $error("trigger longer than one cycle");
    run_gate_a: assert property (!run [*6] |-> !trigger)
        else $error("trigger while stopped");
    thresh_man_a: assert property (up == 2'h3 && $past(thresh_manual)
        |-> thresh_manual_out && thresh_level_out == $past(thresh_level))
        else $error("manual level not passed on");
    thresh_auto_a: assert property (up == 2'h3 && !$past(thresh_manual)
        |-> !thresh_manual_out && thresh_level_out == 8'h80)
        else $error("automatic level wrong");
    i2c_start_a: assert property (run && proto == proto_i2c && i2c_cond == i2c_start ##0 start_pin
        |-> ##[3:6] trigger)
        else $error("start missed");
    i2c_stop_a: assert property (run && proto == proto_i2c && i2c_cond == i2c_stop ##0 stop_pin
        |-> ##[3:6] trigger)
        else $error("stop missed");
    busy_start_a: assert property (proto == proto_i2c ##0 start_pin |-> ##[3:6] busy)
        else $error("not busy after start");
    busy_stop_a: assert property (proto == proto_i2c ##0 stop_pin |-> ##[3:6] !busy)
        else $error("busy after stop");
endmodule // trig_detector_sva

// File: bench/bus_model.sv
// Model of the target's bus lines seen on the input channels.
// Assumes lines move at the falling edge of the detector clock.
`timescale 1ns/1ps
module bus_model
(
    input  wire logic       clk,
    output logic      [5:0] lines
);
    // ==========
    // Helpers; released lines sit at the pull-up level
    initial lines = 6'h3f;
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pin(int ch, logic v, int n = 8);
        lines[ch] = v;
        tick(n);
    endtask
    // ==========
    // I2C; works as a repeated start when the clock is low
    task automatic go();
        pin(0, 1'b1);
        pin(1, 1'b1);
        pin(0, 1'b0);
        pin(1, 1'b0);
    endtask
    task automatic halt();
        pin(0, 1'b0);
        pin(1, 1'b1);
        pin(0, 1'b1);
    endtask
    task automatic unit(logic [7:0] b, logic nack);
        for (int i = 7; i >= 0; i--)
        begin
            pin(0, b[i]);
            pin(1, 1'b1);
            pin(1, 1'b0);
        end
        pin(0, nack);
        pin(1, 1'b1);
        pin(1, 1'b0);
        pin(0, 1'b1); // Slave lets go, pull-up wins
    endtask
    // Address, refused data, repeated start, address again
    task automatic frame(logic [7:0] a);
        go();
        unit(a, 1'b0);
        unit(8'h5a, 1'b1);
        go();
        unit(a, 1'b0);
        halt();
    endtask
    // ==========
    // CAN pair and LIN line
    // Single wire idles high on ch0 and pulls it low when dominant
    task automatic can_bits(logic dom, int n, logic single = 1'b0);
        lines[1:0] = single ? {1'b1, ~dom} : (dom ? 2'b01 : 2'b10);
        tick(n);
    endtask
    task automatic lin_low(int n, int ch = 0);
        pin(ch, 1'b0, n);
        pin(ch, 1'b1, 256);
    endtask
endmodule // bus_model

// File: bench/tb_trig_detector.sv
// Self-checking bench for the protocol trigger detector.
// Assumes bus_model on the channels and the checker bound below.
`timescale 1ns/1ps
`include "trig_params.svh"
module tb_trig_detector
    import trig_pkg::*;
;
    logic              clk;
    logic              resetn;
    logic [5:0]        chan_in;
    logic              run;
    proto_type         proto;
    logic              can_on_end;
    can_sig_type       can_sig;
    logic [1:0]        trig_source;
    logic [`DIV_W-1:0] bit_div;
    logic [1:0]        brk_len;
    i2c_cond_type      i2c_cond;
    logic              addr10_en;
    logic              thresh_manual;
    logic [7:0]        thresh_level;
    logic              trigger;
    logic              thresh_manual_out;
    logic [7:0]        thresh_level_out;
    logic              addr10_seen;
    logic              read_seen;
    logic              busy;
    int                mismatches = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                step = 0;
    int                seed = 32'h6ec9f6ba;
    int                exp_q[$];

    trig_detector dut (.clk(clk), .resetn(resetn), .chan_in(chan_in), .run(run), .proto(proto),
        .can_on_end(can_on_end), .can_sig(can_sig), .trig_source(trig_source), .bit_div(bit_div),
        .brk_len(brk_len), .i2c_cond(i2c_cond), .addr10_en(addr10_en), .thresh_manual(thresh_manual),
        .thresh_level(thresh_level), .trigger(trigger), .thresh_manual_out(thresh_manual_out),
        .thresh_level_out(thresh_level_out), .addr10_seen(addr10_seen), .read_seen(read_seen),
        .busy(busy));
    bus_model m (.clk(clk), .lines(chan_in));

    // ==========
    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail("timeout");
            close_out();
        end
    end
    // ==========
    // Reporting and comparison
    task automatic fail(string msg);
        $display("unexpected at %0t: %s", $time, msg);
        mismatches++;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
        samples_checked++;
        if (got !== exp)
            fail(what);
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Each trigger must belong to a note left by the current step; read at the falling edge, once settled
    always @(negedge clk)
    begin
        if (resetn === 1'b1 && trigger === 1'b1)
        begin
            samples_checked++;
            if (exp_q.size() == 0)
                fail("trigger not expected");
            else if (exp_q.pop_front() != step)
                fail("trigger in wrong step");
        end
    end
    task automatic expect_n(int n);
        repeat (n) exp_q.push_back(step);
    endtask
    task automatic end_step(string name);
        repeat (40) @(negedge clk);
        samples_checked++;
        if (exp_q.size() != 0)
            fail("trigger missing");
        exp_q.delete();
        $display("test %s done", name);
        step++;
    endtask
    // Acquisition is stopped for eight cycles after a config change, then restarted
    task automatic arm();
        run = 1'b0;
        repeat (8) @(negedge clk);
        run = 1'b1;
    endtask
    // ==========
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        run = 1'b1;
        proto = proto_i2c;
        can_on_end = 1'b0;
        can_sig = can_high_speed;
        trig_source = 2'h0;
        bit_div = 15'h0040;
        brk_len = 2'h1;
        i2c_cond = i2c_start;
        addr10_en = 1'b0;
        thresh_manual = 1'b0;
        thresh_level = 8'h00;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        // Every I2C condition on a frame with a repeated start
        for (int i = 0; i < 4; i++)
        begin
            i2c_cond = i2c_cond_type'(i);
            addr10_en = i[0];
            thresh_manual = (i == 0) | 1'($random(seed)); // First pass always exercises manual mode
            thresh_level = 8'($random(seed));
            arm();
            expect_n(i == 0 ? 2 : 1);
            m.frame(8'hf2 | 8'(i[1]));
            chk(8'(addr10_seen), 8'(i == 1), "ten-bit write");
            chk(8'(read_seen), 8'(i[1]), "direction");
            chk(8'(thresh_manual_out), 8'(thresh_manual), "threshold mode");
            chk(thresh_level_out, thresh_manual ? thresh_level : 8'h80, "threshold level");
            end_step("i2c condition");
        end
        // Stopped acquisition gives no trigger
        run = 1'b0;
        i2c_cond = i2c_start;
        m.frame(8'ha0);
        end_step("stopped");
        // Protocol off gives no trigger either
        proto = proto_off;
        run = 1'b1;
        m.frame(8'ha0);
        end_step("off");
        // LIN break just short of and just past each minimum
        proto = proto_lin;
        for (int k = 1; k < 4; k++)
        begin
            brk_len = 2'(k);
            arm();
            m.lin_low(64 * (9 + k) + 32);
            expect_n(1);
            m.lin_low(64 * (10 + k) + 32);
            end_step("lin break");
        end
        // Break on a channel other than the source is ignored
        trig_source = 2'h1;
        arm();
        m.lin_low(64 * 14 + 32);
        expect_n(1);
        m.lin_low(64 * 14 + 32, 1);
        end_step("lin source");
        trig_source = 2'h0;
        // CAN start and end on the pair, then start on the single wire line
        proto = proto_can;
        bit_div = 15'h0028;
        for (int e = 0; e < 3; e++)
        begin
            m.can_bits(1'b0, 8, e == 2);
            can_on_end = e[0];
            can_sig = can_sig_type'(e);
            arm();
            m.can_bits(1'b0, 40 * 15, e == 2);
            expect_n(1);
            m.can_bits(1'b1, 40 * 3, e == 2);
            m.can_bits(1'b0, 40 * 12, e == 2);
            end_step("can frame");
        end
        close_out();
    end
endmodule // tb_trig_detector

bind trig_detector trig_detector_sva chk (.clk(clk), .resetn(resetn), .chan_in(chan_in), .run(run),
    .proto(proto), .i2c_cond(i2c_cond), .thresh_manual(thresh_manual), .thresh_level(thresh_level),
    .trigger(trigger), .thresh_manual_out(thresh_manual_out), .thresh_level_out(thresh_level_out),
    .busy(busy));
